// ==== src/asqp_defines.vh ====
// Function
// - Character format: 7/8 data, 1/2 stop, parity.
// - Baud 1200 to 115200, default 9600.
// - TCP port 9882, four independent connections.
// - Address 0..127, three chars, zero/space padded; leading spaces only taken in queries.
// - Frame opens STX, ends ETX or CR.
// - ETX brings two checksum chars; CR none.
// - Checksum XORs all chars from zero incl. framing.
// - Checksum two hex chars, high nibble first.
// - Space is 0x20, only where allowed.
// - Letters N, K, M request zero, span, sample.
// - Mode letters act only outside service, option fitted.
// - Control frame: code, address, space, letter, terminator; the code also takes the letter with no space before it.
// - Bad or misaddressed control frames silently dropped.
// - Accepted query starts a measurement reply.
// - Query without address allows no space.
// - Query answered only when fully valid.
// - Reply ends with the command's terminator.
// - Reply opens with tag and two-digit count.
`ifndef ASQP_DEFINES_VH
`define ASQP_DEFINES_VH
`define ASQP_CH_STX      8'h02
`define ASQP_CH_ETX      8'h03
`define ASQP_CH_CR       8'h0D
`define ASQP_CH_SP       8'h20
`define ASQP_CH_ZERO     8'h30
`define ASQP_CH_NINE     8'h39
`define ASQP_CH_UA       8'h41
`define ASQP_CH_UF       8'h46
`define ASQP_CH_CTL0     8'h53
`define ASQP_CH_CTL1     8'h54
`define ASQP_CH_QRY0     8'h44
`define ASQP_CH_QRY1     8'h41
`define ASQP_CH_ZEROGAS  8'h4E
`define ASQP_CH_SPANGAS  8'h4B
`define ASQP_CH_SAMPLE   8'h4D
`define ASQP_MODE_ZERO   2'h1
`define ASQP_MODE_SPAN   2'h2
`define ASQP_MODE_SAMPLE 2'h3
`define ASQP_BAUD_DEF    17'h02580
`define ASQP_TCP_PORT    16'h269A
`define ASQP_ADDR_MAX    7'h7F
`define ASQP_REG_CTRL    32'h00000000
`define ASQP_REG_STAT    32'h00000004
`define ASQP_REG_RXDATA  32'h00000008
`define ASQP_REG_EVENT   32'h0000000C
`define ASQP_REG_BAUD    32'h00000010
`define ASQP_CTRL_ADDR_LSB 0
`define ASQP_CTRL_SERVICE  8
`define ASQP_CTRL_ZSOPT    9
`define ASQP_CTRL_DBITS8   10
`define ASQP_CTRL_STOP2    11
`define ASQP_CTRL_PAR_LSB  12
`define ASQP_CTRL_CHAN_LSB 16
`define ASQP_CTRL_RESET    32'h00000200
`endif

// ==== src/asqp_fifo.v ====
module asqp_fifo #(
    parameter WIDTH = 10,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             i_sys_clk,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_in_data,
    input  wire             i_in_valid,
    output wire             o_in_ready,
    output wire [WIDTH-1:0] o_out_data,
    output wire             o_out_valid,
    input  wire             i_out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;
    integer         k;

    assign o_in_ready  = (cnt_q != DEPTH);
    assign o_out_valid = (cnt_q != 0);
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            for (k = 0; k < DEPTH; k = k + 1)
                mem_q[k] <= {WIDTH{1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_q] <= i_in_data;
                wr_q        <= wr_q + 1'b1;
            end
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule

// ==== src/asqp_top.v ====
`include "asqp_defines.vh"
module asqp_top #(
    parameter NCHAN = 4
) (
    input  wire        i_sys_clk,
    input  wire        i_rst_n,
    input  wire [7:0]  i_rx_data,
    input  wire [1:0]  i_rx_chan,
    input  wire        i_rx_valid,
    output wire        o_rx_ready,
    output reg  [1:0]  o_mode_req,
    output reg         o_mode_valid,
    output reg         o_query_start,
    output reg  [1:0]  o_query_chan,
    output reg         o_query_etx,
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    localparam S_IDLE = 7'h01;
    localparam S_C1   = 7'h02;
    localparam S_BODY = 7'h04;
    localparam S_HI   = 7'h08;
    localparam S_LO   = 7'h10;
    localparam S_DONE = 7'h20;
    localparam S_DROP = 7'h40;

    reg  [31:0] ctrl_q;
    reg  [16:0] baud_q;
    reg  [2:0]  evt_q;
    reg         aw_q;
    reg         w_q;
    reg  [31:0] awaddr_q;
    reg  [31:0] wdata_q;

    wire [9:0]  f_data;
    wire        f_valid;
    wire        f_ready;
    wire [7:0]  ch;
    wire [1:0]  cn;
    wire [6:0]  station;

    reg  [6:0]  st_q [0:NCHAN-1];
    reg  [7:0]  bcc_q [0:NCHAN-1];
    reg         qry_q [0:NCHAN-1];
    reg  [1:0]  na_q [0:NCHAN-1];
    reg  [6:0]  av_q [0:NCHAN-1];
    reg         adsp_q [0:NCHAN-1];
    reg         sp_q [0:NCHAN-1];
    reg  [7:0]  let_q [0:NCHAN-1];
    reg         etx_q [0:NCHAN-1];
    reg  [3:0]  hi_q [0:NCHAN-1];
    reg         bad_q [0:NCHAN-1];

    reg         is_hex;
    reg  [3:0]  hexv;
    reg         is_dig;
    wire [7:0]  rx_byte;

    assign station = ctrl_q[`ASQP_CTRL_ADDR_LSB+6:`ASQP_CTRL_ADDR_LSB];
    assign rx_byte = ctrl_q[`ASQP_CTRL_DBITS8] ? i_rx_data :
                     {1'b0, i_rx_data[6:0]};

    asqp_fifo #(
        .WIDTH(10),
        .DEPTH(16),
        .AW   (4)
    ) u_fifo (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_in_data  ({i_rx_chan, rx_byte}),
        .i_in_valid (i_rx_valid),
        .o_in_ready (o_rx_ready),
        .o_out_data (f_data),
        .o_out_valid(f_valid),
        .i_out_ready(f_ready)
    );

    assign f_ready = 1'b1;
    assign ch      = f_data[7:0];
    assign cn      = f_data[9:8];

    always @*
    begin
        is_dig = (ch >= `ASQP_CH_ZERO) && (ch <= `ASQP_CH_NINE);
        is_hex = is_dig || ((ch >= `ASQP_CH_UA) && (ch <= `ASQP_CH_UF));
        hexv   = is_dig ? ch[3:0] : ch[3:0] + 4'h9;
    end

    // Each connection keeps its own parse context.
    genvar g;
    generate
        for (g = 0; g < NCHAN; g = g + 1)
        begin : g_chan
            wire        hit;
            wire [7:0]  x;
            wire [9:0]  acc;
            wire [7:0]  rx_bcc;
            assign hit = f_valid && (cn == g);
            assign x   = bcc_q[g] ^ ch;
            assign acc = {av_q[g], 3'h0} + {2'h0, av_q[g], 1'b0}
                         + {6'h00, ch[3:0]};
            assign rx_bcc = {hi_q[g], hexv};
            always @(posedge i_sys_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    st_q[g]   <= S_IDLE;
                    bcc_q[g]  <= 8'h00;
                    qry_q[g]  <= 1'b0;
                    na_q[g]   <= 2'h0;
                    av_q[g]   <= 7'h00;
                    adsp_q[g] <= 1'b0;
                    sp_q[g]   <= 1'b0;
                    let_q[g]  <= 8'h00;
                    etx_q[g]  <= 1'b0;
                    hi_q[g]   <= 4'h0;
                    bad_q[g]  <= 1'b0;
                end
                else if (hit && ch == `ASQP_CH_STX)
                begin
                    // Restart on any start character.
                    st_q[g]   <= S_C1;
                    bcc_q[g]  <= `ASQP_CH_STX;
                    na_q[g]   <= 2'h0;
                    av_q[g]   <= 7'h00;
                    adsp_q[g] <= 1'b0;
                    sp_q[g]   <= 1'b0;
                    let_q[g]  <= 8'h00;
                    hi_q[g]   <= 4'h0;
                    bad_q[g]  <= 1'b0;
                end
                else if (hit)
                begin
                    bcc_q[g] <= x;
                    case (st_q[g])
                        S_C1:
                        begin
                            if (ch == `ASQP_CH_CTL0 || ch == `ASQP_CH_QRY0)
                            begin
                                qry_q[g] <= (ch == `ASQP_CH_QRY0);
                                st_q[g]  <= S_HI;
                                etx_q[g] <= 1'b1;
                            end
                            else
                                st_q[g] <= S_DROP;
                        end
                        S_BODY:
                        begin
                            if (ch == `ASQP_CH_ETX || ch == `ASQP_CH_CR)
                            begin
                                // Terminator alone picks checksum.
                                etx_q[g] <= (ch == `ASQP_CH_ETX);
                                st_q[g]  <= (ch == `ASQP_CH_ETX) ?
                                            S_HI : S_DONE;
                                if (na_q[g] == 2'h1 || na_q[g] == 2'h2)
                                    bad_q[g] <= 1'b1;
                            end
                            else if (ch == `ASQP_CH_SP)
                            begin
                                sp_q[g] <= 1'b1;
                                if (na_q[g] == 2'h0 && !qry_q[g] &&
                                    !adsp_q[g])
                                    adsp_q[g] <= 1'b1;
                                else if (na_q[g] == 2'h3 && !adsp_q[g] &&
                                         let_q[g] == 8'h00)
                                    adsp_q[g] <= 1'b1;
                                else if (na_q[g] == 2'h0 && qry_q[g])
                                    na_q[g] <= 2'h1;
                                else if ((na_q[g] == 2'h1) &&
                                         (av_q[g] == 7'h00))
                                    na_q[g] <= 2'h2;
                                else
                                    bad_q[g] <= 1'b1;
                            end
                            else if (is_dig && na_q[g] != 2'h3 &&
                                     !(adsp_q[g] && na_q[g] == 2'h0) &&
                                     let_q[g] == 8'h00)
                            begin
                                // Pad with zeros, or with leading spaces in queries.
                                na_q[g] <= na_q[g] + 2'h1;
                                if (acc > {3'h0, `ASQP_ADDR_MAX})
                                    av_q[g] <= 7'h7F;
                                else
                                    av_q[g] <= acc[6:0];
                                if (acc > {3'h0, `ASQP_ADDR_MAX})
                                    bad_q[g] <= 1'b1;
                            end
                            else if (!qry_q[g] && let_q[g] == 8'h00 &&
                                     (ch == `ASQP_CH_ZEROGAS ||
                                      ch == `ASQP_CH_SPANGAS ||
                                      ch == `ASQP_CH_SAMPLE))
                                let_q[g] <= ch;
                            else
                                bad_q[g] <= 1'b1;
                        end
                        S_HI:
                        begin
                            if (!etx_q[g] || !is_hex)
                                st_q[g] <= S_DROP;
                            else
                            begin
                                hi_q[g]  <= hexv;
                                bcc_q[g] <= bcc_q[g];
                                st_q[g]  <= S_LO;
                            end
                        end
                        S_LO:
                        begin
                            bcc_q[g] <= bcc_q[g];
                            if (is_hex && rx_bcc == bcc_q[g])
                                st_q[g] <= S_DONE;
                            else
                                st_q[g] <= S_DROP;
                        end
                        default:
                            st_q[g] <= S_DROP;
                    endcase
                    // Second code character of the two-letter command.
                    if (st_q[g] == S_HI && etx_q[g] && na_q[g] == 2'h0
                        && let_q[g] == 8'h00 && bcc_q[g] == (`ASQP_CH_STX
                        ^ (qry_q[g] ? `ASQP_CH_QRY0 : `ASQP_CH_CTL0))
                        && !sp_q[g] && !bad_q[g] && !adsp_q[g] &&
                        hi_q[g] == 4'h0)
                    begin
                        bcc_q[g] <= x;
                        etx_q[g] <= 1'b0;
                        hi_q[g]  <= 4'hF;
                        st_q[g]  <= (ch == (qry_q[g] ? `ASQP_CH_QRY1 :
                                     `ASQP_CH_CTL1)) ? S_BODY : S_DROP;
                    end
                end
                else if (st_q[g] == S_DONE)
                begin
                    st_q[g] <= S_IDLE;
                    hi_q[g] <= 4'h0;
                end
                else if (st_q[g] == S_DROP && hi_q[g] == 4'hF)
                    hi_q[g] <= 4'h0;
            end
        end
    endgenerate

    integer j;
    reg      dn_any;
    reg      dn_ctl;
    reg      dn_qry;
    reg [1:0] dn_ch;
    always @*
    begin
        dn_any = 1'b0;
        dn_ctl = 1'b0;
        dn_qry = 1'b0;
        dn_ch  = 2'h0;
        for (j = 0; j < NCHAN; j = j + 1)
            if (st_q[j] == S_DONE && !dn_any)
            begin
                dn_any = 1'b1;
                dn_ch  = j[1:0];
            end
    end

    wire        dn_ok_ctl;
    wire        dn_ok_qry;
    wire [7:0]  dn_let;
    assign dn_let    = let_q[dn_ch];
    assign dn_ok_ctl = dn_any && !qry_q[dn_ch] && !bad_q[dn_ch] &&
                       dn_let != 8'h00 &&
                       (na_q[dn_ch] == 2'h0 ||
                        (na_q[dn_ch] == 2'h3 && av_q[dn_ch] == station));
    assign dn_ok_qry = dn_any && qry_q[dn_ch] && !bad_q[dn_ch] &&
                       !(na_q[dn_ch] == 2'h0 && sp_q[dn_ch]) &&
                       (na_q[dn_ch] == 2'h0 ||
                        (na_q[dn_ch] == 2'h3 && av_q[dn_ch] == station));

    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_mode_req    <= 2'h0;
            o_mode_valid  <= 1'b0;
            o_query_start <= 1'b0;
            o_query_chan  <= 2'h0;
            o_query_etx   <= 1'b0;
        end
        else
        begin
            // Mode change gated by service and option.
            o_mode_valid  <= dn_ok_ctl && !ctrl_q[`ASQP_CTRL_SERVICE] &&
                             ctrl_q[`ASQP_CTRL_ZSOPT];
            o_mode_req    <= (dn_let == `ASQP_CH_ZEROGAS) ?
                             `ASQP_MODE_ZERO :
                             (dn_let == `ASQP_CH_SPANGAS) ?
                             `ASQP_MODE_SPAN : `ASQP_MODE_SAMPLE;
            o_query_start <= dn_ok_qry;
            if (dn_ok_qry)
            begin
                o_query_chan <= dn_ch;
                o_query_etx  <= etx_q[dn_ch];
            end
        end
    end

    // Register slave.
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            aw_q         <= 1'b0;
            w_q          <= 1'b0;
            awaddr_q     <= 32'h00000000;
            wdata_q      <= 32'h00000000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h00000000;
            ctrl_q       <= `ASQP_CTRL_RESET;
            baud_q       <= `ASQP_BAUD_DEF;
            evt_q        <= 3'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q     <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q     <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (aw_q && w_q)
            begin
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'h0;
                if (awaddr_q[7:2] == `ASQP_REG_CTRL >> 2)
                    ctrl_q <= wdata_q;
                else if (awaddr_q[7:2] == `ASQP_REG_BAUD >> 2)
                    baud_q <= wdata_q[16:0];
                else if (awaddr_q[7:2] == `ASQP_REG_EVENT >> 2)
                    evt_q <= evt_q & ~wdata_q[2:0];
                else
                    s_axi_bresp <= 2'h2;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (o_query_start)
                evt_q[0] <= 1'b1;
            if (o_mode_valid)
                evt_q[1] <= 1'b1;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr[7:2])
                    6'h00: s_axi_rdata <= ctrl_q;
                    6'h01: s_axi_rdata <= {24'h0, 6'h0, o_query_chan};
                    6'h02: s_axi_rdata <= {22'h0, f_data};
                    6'h03: s_axi_rdata <= {29'h0, evt_q};
                    6'h04: s_axi_rdata <= {15'h0, baud_q};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ==== dv/asqp_checker_assertions.sv ====
module asqp_checker #(
    parameter NCHAN = 4
) (
    input logic       i_sys_clk,
    input logic       i_rst_n,
    input logic       i_rx_valid,
    input logic       o_rx_ready,
    input logic [1:0] o_mode_req,
    input logic       o_mode_valid,
    input logic       o_query_start,
    input logic [1:0] o_query_chan,
    input logic       s_axi_arvalid,
    input logic       s_axi_arready,
    input logic       s_axi_rvalid,
    input logic [1:0] s_axi_rresp
);
    logic [7:0] idle_q;
    logic [7:0] idle_d;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_action;
        o_query_start || o_mode_valid;
    endsequence
    // Cycles since the last character was taken, saturating.
    assign idle_d = (i_rx_valid && o_rx_ready) ? 8'h00 :
                    (idle_q == 8'hFF) ? idle_q : idle_q + 8'h01;
    always @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            idle_q <= 8'h00;
        else
            idle_q <= idle_d;
    end
    chk_mode_code: assert property (o_mode_valid |-> o_mode_req != 2'h0)
        else $error("mode pulse without a mode code");
    chk_mode_pulse: assert property (o_mode_valid |=> !o_mode_valid)
        else $error("mode pulse longer than one cycle");
    chk_query_pulse: assert property (o_query_start |=> !o_query_start)
        else $error("query pulse longer than one cycle");
    chk_one_action: assert property (!(o_mode_valid && o_query_start))
        else $error("mode and query from one frame");
    chk_action_cause: assert property (s_action |-> idle_q < 8'd40)
        else $error("action without a recent frame");
    chk_query_chan: assert property (o_query_start |-> o_query_chan < NCHAN)
        else $error("query on a channel that does not exist");
    chk_rd_latency: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    chk_rresp_code: assert property (s_axi_rvalid |-> s_axi_rresp[0] == 1'b0)
        else $error("read response neither okay nor slave error");
    chk_ready_reset: assert property ($rose(i_rst_n) |-> o_rx_ready)
        else $error("receive path not ready after reset");
endmodule
bind asqp_top asqp_checker #(.NCHAN(NCHAN)) chk_u (.i_sys_clk, .i_rst_n,
    .i_rx_valid, .o_rx_ready, .o_mode_req, .o_mode_valid, .o_query_start,
    .o_query_chan, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rresp);

// ==== dv/asqp_host_model.sv ====
module asqp_host_model (
    input  logic       i_sys_clk,
    input  logic       i_rx_ready,
    output logic [7:0] o_rx_data,
    output logic [1:0] o_rx_chan,
    output logic       o_rx_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_rx_data = 8'h00;
        o_rx_chan = 2'h0;
        o_rx_valid = 1'b0;
    end
    function automatic logic [7:0] hex(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction
    // Characters are eight bits; the bench keeps them within seven.
    task automatic put(input logic [7:0] c, input int gap);
        if (gap > 0)
        begin
            o_rx_valid <= 1'b0;
            o_rx_data <= ~o_rx_data;
            repeat (gap) @(posedge i_sys_clk);
        end
        o_rx_data <= c;
        o_rx_valid <= 1'b1;
        @(posedge i_sys_clk);
        while (!i_rx_ready) @(posedge i_sys_clk);
    endtask
    task automatic frame(input string s, input bit etx, bad,
                         input logic [1:0] ch, input int gap);
        logic [7:0] sum;
        int i;
        sum = 8'h00;
        o_rx_chan <= ch;
        put(8'h02, gap);
        sum = sum ^ 8'h02;
        for (i = 0; i < s.len(); i++)
        begin
            put(s[i], gap);
            sum = sum ^ s[i];
        end
        if (etx)
        begin
            put(8'h03, gap);
            sum = sum ^ 8'h03 ^ {7'h00, bad};
            put(hex(sum[7:4]), gap);
            put(hex(sum[3:0]), gap);
        end
        else
            put(8'h0D, gap);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~o_rx_data;
        @(posedge i_sys_clk);
    endtask
endmodule

// ==== dv/asqp_top_bench.sv ====
`include "asqp_defines.vh"
module asqp_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_sys_clk, i_rst_n, i_rx_valid, o_rx_ready;
    logic [7:0]  i_rx_data;
    logic [1:0]  i_rx_chan, o_mode_req, o_query_chan, r;
    logic        o_mode_valid, o_query_start, o_query_etx;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, q_etx;
    logic [1:0]  s_axi_bresp, s_axi_rresp, q_chan, m_req;
    int          miscompares, total_checks, q_cnt, m_cnt;
    asqp_top dut_u (.i_sys_clk, .i_rst_n, .i_rx_data, .i_rx_chan,
        .i_rx_valid, .o_rx_ready, .o_mode_req, .o_mode_valid, .o_query_start,
        .o_query_chan, .o_query_etx, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    asqp_host_model host_u (.i_sys_clk, .i_rx_ready(o_rx_ready),
        .o_rx_data(i_rx_data), .o_rx_chan(i_rx_chan), .o_rx_valid(i_rx_valid));
    initial
    begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk)
    begin
        if (o_query_start === 1'b1)
        begin
            q_cnt <= q_cnt + 1;
            q_etx <= o_query_etx;
            q_chan <= o_query_chan;
        end
        if (o_mode_valid === 1'b1)
        begin
            m_cnt <= m_cnt + 1;
            m_req <= o_mode_req;
        end
    end
    task automatic end_of_test();
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [31:0] a, v);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= v;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge i_sys_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic axi_rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge i_sys_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd_chk(input logic [31:0] a, exp);
        axi_rd(a);
        check(d, exp);
        check(r, 2'h0);
    endtask
    task automatic run(input string s, input bit etx, bad,
        input logic [1:0] ch, input int gap, input logic [1:0] md, input bit qy);
        int q0, m0;
        q0 = q_cnt;
        m0 = m_cnt;
        host_u.frame(s, etx, bad, ch, gap);
        repeat (30) @(posedge i_sys_clk);
        check(q_cnt - q0, qy);
        check(m_cnt - m0, md != 2'h0);
        if (qy)
        begin
            check(q_etx, etx);
            check(q_chan, ch);
        end
        if (md != 2'h0)
            check(m_req, md);
    endtask
    initial
    begin
        {i_rst_n, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, q_cnt, m_cnt} = '0;
        s_axi_wstrb = 4'hF;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        rd_chk(`ASQP_REG_CTRL, 32'h00000200);
        rd_chk(`ASQP_REG_BAUD, 32'h00002580);
        axi_rd(32'h00000020);
        check(r, 2'h2);
        axi_wr(32'h00000020, 32'h0);
        check(r, 2'h2);
        axi_wr(`ASQP_REG_CTRL, 32'h00000205);
        check(r, 2'h0);
        run("DA", 0, 0, 2'h0, 0, 2'h0, 1);
        run("DA", 1, 0, 2'h1, 0, 2'h0, 1);
        run("DA", 1, 1, 2'h1, 0, 2'h0, 0);
        run("DA005", 0, 0, 2'h2, 2, 2'h0, 1);
        run("DA  5", 1, 0, 2'h3, 0, 2'h0, 1);
        run("DA006", 0, 0, 2'h0, 0, 2'h0, 0);
        run("DA ", 0, 0, 2'h0, 0, 2'h0, 0);
        run("ST005 N", 0, 0, 2'h0, 0, 2'h1, 0);
        run("STK", 1, 0, 2'h0, 3, 2'h2, 0);
        run("ST005M", 1, 1, 2'h0, 0, 2'h0, 0);
        run("ST005M", 1, 0, 2'h0, 0, 2'h3, 0);
        run("ST007N", 0, 0, 2'h0, 0, 2'h0, 0);
        run("ST005  N", 0, 0, 2'h0, 0, 2'h0, 0);
        run("STQ", 0, 0, 2'h0, 0, 2'h0, 0);
        run("ST0\002DA", 0, 0, 2'h1, 0, 2'h0, 1);
        rd_chk(`ASQP_REG_STAT, 32'h00000001);
        rd_chk(`ASQP_REG_EVENT, 32'h00000003);
        axi_wr(`ASQP_REG_EVENT, 32'h00000003);
        rd_chk(`ASQP_REG_EVENT, 32'h00000000);
        axi_wr(`ASQP_REG_CTRL, 32'h00000305);
        run("STN", 0, 0, 2'h0, 0, 2'h0, 0);
        axi_wr(`ASQP_REG_CTRL, 32'h00000005);
        run("STN", 0, 0, 2'h0, 0, 2'h0, 0);
        axi_wr(`ASQP_REG_CTRL, 32'h00000205);
        run("STN", 1, 0, 2'h0, 0, 2'h1, 0);
        end_of_test();
    end
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        miscompares++;
        end_of_test();
    end
endmodule
